// [core/csl_blink_div.v]
/*
 free-running divider producing a square blink phase.
 assumes a synchronous active-low reset and a half period of at least 1.
*/
`include "csl_consts.vh"

module csl_blink_div #(
    parameter HALF = 1000
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // phase out
    output reg         phase
);
    reg [31:0] count;

    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= 32'h0000_0000;
            phase <= 1'b0;
        end else if (count == HALF - 1) begin
            count <= 32'h0000_0000;
            phase <= ~phase;
        end else begin
            count <= count + 32'h0000_0001;
        end
    end
endmodule

// [core/csl_consts.vh]
/*
 status led controller constants: register offsets, fields, resets, timing.
 assumes a 40 MHz aclk and a 32-bit axi4-lite register bus.
*/
`ifndef CSL_CONSTS_VH
`define CSL_CONSTS_VH

// register byte offsets
`define CSL_REG_CTRL        8'h00
`define CSL_REG_LINK        8'h04
`define CSL_REG_STATUS      8'h08
`define CSL_REG_IRQ_STAT    8'h0C
`define CSL_REG_IRQ_MASK    8'h10

// ctrl fields
`define CSL_CTRL_INIT_DONE  0
`define CSL_CTRL_TRIG_MODE  1
`define CSL_CTRL_POCXP      2
`define CSL_CTRL_OLD_VER    3
`define CSL_CTRL_RESET      4'h0

// link register fields
`define CSL_LINK_STATE_LO   0
`define CSL_LINK_STATE_HI   2
`define CSL_LINK_RATE_LO    4
`define CSL_LINK_RATE_HI    5
`define CSL_LINK_RESET      32'h0000_0000

// link states
`define CSL_LS_DOWN         3'h0
`define CSL_LS_POWERUP      3'h1
`define CSL_LS_NOCONN       3'h2
`define CSL_LS_DETECT       3'h3
`define CSL_LS_CONNECTED    3'h4
`define CSL_LS_WAIT_EVENT   3'h5
`define CSL_LS_SENDING      3'h6
`define CSL_LS_TEST         3'h7

// lane rate configurations, one lane each
`define CSL_RATE_HIGH       2'h0
`define CSL_RATE_MID        2'h1
`define CSL_RATE_LOW        2'h2

// led colour codes {red, green}
`define CSL_LED_OFF         2'h0
`define CSL_LED_GREEN       2'h1
`define CSL_LED_RED         2'h2
`define CSL_LED_AMBER       2'h3

// irq bits
`define CSL_IRQ_TRIG        0
`define CSL_IRQ_RATE_REJ    1
`define CSL_IRQ_DET_DONE    2
`define CSL_IRQ_W           3

// timing
`define CSL_CLK_HZ          40000000
`define CSL_DETECT_MS       1000
`define CSL_DETECT_CYC      ((`CSL_CLK_HZ / 1000) * `CSL_DETECT_MS)
`define CSL_SLOW_MS         500
`define CSL_FAST_MS         100
`define CSL_SLOW_CYC        ((`CSL_CLK_HZ / 1000) * `CSL_SLOW_MS)
`define CSL_FAST_CYC        ((`CSL_CLK_HZ / 1000) * `CSL_FAST_MS)
`define CSL_TRIG_HOLD_MS    200

`endif

// [core/csl_status_led.v]
/*
 status led controller: power/trigger indicator and link indicator with an
 axi4-lite register file and a masked interrupt.
 assumes aclk at 40 MHz, synchronous active-low aresetn, trigger pulses
 synchronous to aclk, and one outstanding read and write on the bus.
*/
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`include "csl_consts.vh"

module csl_status_led #(
    parameter DETECT_CYC    = `CSL_DETECT_CYC,
    parameter SLOW_HALF     = `CSL_SLOW_CYC,
    parameter FAST_HALF     = `CSL_FAST_CYC,
    parameter TRIG_HOLD_CYC = (`CSL_CLK_HZ / 1000) * `CSL_TRIG_HOLD_MS
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // camera events
    input  wire        trigger_pulse,
    // indicators {red, green}
    output reg  [1:0]  power_trigger_indicator,
    output reg  [1:0]  link_indicator,
    // interrupt
    output reg         irq
);
    // control and status
    reg [3:0]  ctrl;
    reg [2:0]  link_req;
    reg [2:0]  link_state;
    reg [1:0]  lane_rate_config;
    reg [`CSL_IRQ_W-1:0] irq_stat;
    reg [`CSL_IRQ_W-1:0] irq_mask;
    reg [31:0] detect_count;
    reg [31:0] trig_count;
    reg        trig_active;
    reg        rate_rej;
    reg        det_done;

    // bus capture
    reg [7:0]  aw_addr;
    reg        aw_held;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    reg        w_held;

    wire       slow_ph;
    wire       fast_ph;
    wire       trig_ph;
    wire       negotiated_protocol_version;

    assign negotiated_protocol_version = ctrl[`CSL_CTRL_OLD_VER];

    csl_blink_div #(.HALF(SLOW_HALF)) u_slow (
        .aclk    (aclk),
        .aresetn (aresetn),
        .phase   (slow_ph)
    );
    csl_blink_div #(.HALF(FAST_HALF)) u_fast (
        .aclk    (aclk),
        .aresetn (aresetn),
        .phase   (fast_ph)
    );
    csl_blink_div #(.HALF(FAST_HALF)) u_trig (
        .aclk    (aclk),
        .aresetn (aresetn),
        .phase   (trig_ph)
    );

    function [31:0] strb_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer i;
        begin
            strb_merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    strb_merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    function rate_ok;
        input [1:0] rate;
        input       old_ver;
        begin
            rate_ok = (rate == `CSL_RATE_MID) || (rate == `CSL_RATE_LOW) ||
                      ((rate == `CSL_RATE_HIGH) && !old_ver);
        end
    endfunction

    wire        wr_go = aw_held && w_held && !s_axi_bvalid;
    wire [31:0] ctrl_new = strb_merge({28'h0000000, ctrl}, w_data, w_strb);
    wire [31:0] link_new = strb_merge({26'h0000000, lane_rate_config,
                                       1'b0, link_req}, w_data, w_strb);
    wire [31:0] mask_new = strb_merge({29'h0000000, irq_mask}, w_data,
                                      w_strb);
    wire        wr_link  = wr_go && (aw_addr == `CSL_REG_LINK);
    wire [1:0]  rate_wr  = link_new[`CSL_LINK_RATE_HI:`CSL_LINK_RATE_LO];

    // write channel capture, either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `CSL_REG_CTRL, `CSL_REG_LINK, `CSL_REG_IRQ_STAT,
                    `CSL_REG_IRQ_MASK: s_axi_bresp <= 2'h0;
                    default:           s_axi_bresp <= 2'h2;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // registers written by software
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl             <= `CSL_CTRL_RESET;
            link_req         <= `CSL_LS_POWERUP;
            lane_rate_config <= `CSL_RATE_LOW;
            irq_mask         <= 3'h0;
            rate_rej         <= 1'b0;
        end else begin
            rate_rej <= 1'b0;
            if (wr_go && aw_addr == `CSL_REG_CTRL) begin
                ctrl <= ctrl_new[3:0];
            end
            if (wr_link) begin
                link_req <= link_new[`CSL_LINK_STATE_HI:`CSL_LINK_STATE_LO];
                if (rate_ok(rate_wr, negotiated_protocol_version)) begin
                    lane_rate_config <= rate_wr;
                end else begin
                    rate_rej <= 1'b1;
                end
            end else if (!rate_ok(lane_rate_config,
                                  negotiated_protocol_version)) begin
                // drop high rate on old version
                lane_rate_config <= `CSL_RATE_MID;
                rate_rej         <= 1'b1;
            end
            if (wr_go && aw_addr == `CSL_REG_IRQ_MASK) begin
                irq_mask <= mask_new[2:0];
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            link_state   <= `CSL_LS_POWERUP;
            detect_count <= 32'h0000_0000;
            det_done     <= 1'b0;
        end else begin
            det_done <= 1'b0;
            if (link_state == `CSL_LS_DETECT &&
                detect_count < DETECT_CYC - 1) begin
                detect_count <= detect_count + 32'h0000_0001;
            end else if (link_req != link_state) begin
                if (link_state == `CSL_LS_DETECT) begin
                    det_done <= 1'b1;
                end
                link_state   <= link_req;
                detect_count <= 32'h0000_0000;
            end
        end
    end

    // trigger activity hold
    always @(posedge aclk) begin
        if (!aresetn) begin
            trig_count  <= 32'h0000_0000;
            trig_active <= 1'b0;
        end else if (trigger_pulse && ctrl[`CSL_CTRL_TRIG_MODE]) begin
            trig_count  <= TRIG_HOLD_CYC - 1;
            trig_active <= 1'b1;
        end else if (trig_count != 32'h0000_0000) begin
            trig_count <= trig_count - 32'h0000_0001;
        end else begin
            trig_active <= 1'b0;
        end
    end

    // indicator drive
    always @(posedge aclk) begin
        if (!aresetn) begin
            power_trigger_indicator <= `CSL_LED_AMBER;
            link_indicator          <= `CSL_LED_AMBER;
        end else begin
            if (!ctrl[`CSL_CTRL_INIT_DONE]) begin
                power_trigger_indicator <= `CSL_LED_AMBER;
            end else if (trig_active && ctrl[`CSL_CTRL_TRIG_MODE]) begin
                power_trigger_indicator <= trig_ph ? `CSL_LED_GREEN
                                                   : `CSL_LED_OFF;
            end else begin
                power_trigger_indicator <= `CSL_LED_GREEN;
            end
            case (link_state)
                `CSL_LS_DOWN:       link_indicator <= `CSL_LED_OFF;
                `CSL_LS_POWERUP:    link_indicator <= `CSL_LED_AMBER;
                `CSL_LS_NOCONN:     link_indicator <=
                    (slow_ph && !ctrl[`CSL_CTRL_POCXP]) ? `CSL_LED_RED
                                                        : `CSL_LED_OFF;
                `CSL_LS_DETECT: begin
                    if (ctrl[`CSL_CTRL_POCXP]) begin
                        link_indicator <= fast_ph ? `CSL_LED_GREEN
                                                  : `CSL_LED_AMBER;
                    end else begin
                        link_indicator <= fast_ph ? `CSL_LED_AMBER
                                                  : `CSL_LED_OFF;
                    end
                end
                `CSL_LS_CONNECTED:  link_indicator <= `CSL_LED_GREEN;
                `CSL_LS_WAIT_EVENT: link_indicator <=
                    slow_ph ? `CSL_LED_AMBER : `CSL_LED_OFF;
                `CSL_LS_SENDING:    link_indicator <=
                    fast_ph ? `CSL_LED_GREEN : `CSL_LED_OFF;
                `CSL_LS_TEST:       link_indicator <=
                    slow_ph ? `CSL_LED_GREEN : `CSL_LED_AMBER;
                default:            link_indicator <= `CSL_LED_OFF;
            endcase
        end
    end

    // sticky interrupt status, set wins over clear
    wire [2:0] irq_set = {det_done, rate_rej,
                          trigger_pulse & ctrl[`CSL_CTRL_TRIG_MODE]};
    wire [2:0] irq_clr = (wr_go && aw_addr == `CSL_REG_IRQ_STAT &&
                          w_strb[0]) ? w_data[2:0] : 3'h0;

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= 3'h0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            irq      <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
        end
    end

    // read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            case (s_axi_araddr)
                `CSL_REG_CTRL:     s_axi_rdata <= {28'h0000000, ctrl};
                `CSL_REG_LINK:     s_axi_rdata <= {26'h0000000,
                                       lane_rate_config, 1'b0, link_req};
                `CSL_REG_STATUS:   s_axi_rdata <= {24'h000000,
                                       power_trigger_indicator,
                                       link_indicator, 1'b0, link_state};
                `CSL_REG_IRQ_STAT: s_axi_rdata <= {29'h0000000, irq_stat};
                `CSL_REG_IRQ_MASK: s_axi_rdata <= {29'h0000000, irq_mask};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// [tb/csl_status_led_bench.sv]
/*
 testbench for the status led controller.
 assumes shortened blink and detect counts set below.
*/
module csl_status_led_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        trigger_pulse;
    logic [1:0]  pti;
    logic [1:0]  li;
    logic        irq;
    logic        irq_s;
    logic        trig_en = 1'b0;
    logic [7:0]  trig_gap = 8'h03;
    logic [1:0]  rsp;
    logic [31:0] rd;
    logic [3:0]  m;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    always #12.5 aclk = ~aclk;

    csl_status_led #(.DETECT_CYC(50), .SLOW_HALF(8), .FAST_HALF(2),
        .TRIG_HOLD_CYC(20)) i_csl_status_led (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .trigger_pulse(trigger_pulse),
        .power_trigger_indicator(pti), .link_indicator(li), .irq(irq));

    csl_trig_src i_csl_trig_src (.aclk(aclk), .aresetn(aresetn),
        .enable(trig_en), .gap(trig_gap), .trigger_pulse(trigger_pulse));

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fail_count++;
            results();
        end
    end

    task automatic check(input string w, input logic [31:0] e,
                         input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic write(input logic [7:0] a, input logic [31:0] d);
        bit ta;
        bit tw;
        bit tb;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic read(input logic [7:0] a);
        bit ta;
        bit tr;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tr);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // colours seen on one indicator over n cycles
    task automatic seen(input bit pw, input int n);
        repeat (2) @(posedge aclk);
        m = 4'h0;
        repeat (n) begin
            @(negedge aclk);
            irq_s = irq;
            if (pw) m[pti] = 1'b1;
            else m[li] = 1'b1;
        end
        @(posedge aclk);
    endtask

    task automatic offrun(output int n);
        int k;
        n = 0;
        k = 0;
        do begin @(negedge aclk); k++; end while (pti === 2'h0 && k < 40);
        do begin @(negedge aclk); k++; end while (pti !== 2'h0 && k < 80);
        while (pti === 2'h0 && n < 40) begin @(negedge aclk); n++; end
        @(posedge aclk);
    endtask

    task automatic t_reset;
        read(8'h08);
        check("status", 32'h0000_00F1, rd);
        read(8'h04);
        check("link", 32'h0000_0021, rd);
        seen(1, 8);
        check("power init", 32'h8, {28'h0, m});
        write(8'h00, 32'h1);
        seen(1, 20);
        check("power ready", 32'h2, {28'h0, m});
        $display("test reset and power done");
    endtask

    task automatic t_trigger;
        int r1;
        int r2;
        write(8'h10, 32'h1);
        write(8'h00, 32'h3);
        trig_en <= 1'b1;
        seen(1, 30);
        check("trig blink", 32'h3, {28'h0, m});
        check("trig irq", 32'h1, {31'h0, irq_s});
        offrun(r1);
        trig_gap <= 8'h07;
        repeat (30) @(posedge aclk);
        offrun(r2);
        check("off run", 32'h1, {31'h0, r1 > 0 && r1 < 40});
        check("cadence", r1, r2);
        trig_en <= 1'b0;
        repeat (25) @(posedge aclk);
        read(8'h0C);
        check("irq stat", 32'h1, rd);
        write(8'h0C, 32'h1);
        seen(1, 8);
        check("trig end", 32'h2, {28'h0, m});
        check("irq clear", 32'h0, {31'h0, irq_s});
        write(8'h10, 32'h0);
        trig_en <= 1'b1;
        seen(1, 4);
        trig_en <= 1'b0;
        check("irq masked", 32'h0, {31'h0, irq_s});
        read(8'h0C);
        check("stat masked", 32'h1, rd);
        write(8'h0C, 32'h1);
        $display("test trigger done");
    endtask

    task automatic t_link;
        logic [3:0] e [8] = '{4'h1, 4'h8, 4'h5, 4'h0, 4'h2, 4'h9, 4'h3, 4'hA};
        write(8'h00, 32'h1);
        for (int s = 0; s < 8; s++) begin
            if (s != 3) begin
                write(8'h04, 32'h20 + 32'(s));
                seen(0, 40);
                check("link", {28'h0, e[s]}, {28'h0, m});
            end
        end
        write(8'h00, 32'h5);
        write(8'h04, 32'h22);
        seen(0, 40);
        check("pocxp noconn", 32'h1, {28'h0, m});
        write(8'h10, 32'h4);
        write(8'h04, 32'h23);
        write(8'h04, 32'h24);
        seen(0, 30);
        check("pocxp detect", 32'hA, {28'h0, m});
        repeat (20) @(posedge aclk);
        seen(0, 8);
        check("connected", 32'h2, {28'h0, m});
        check("detect irq", 32'h1, {31'h0, irq_s});
        write(8'h0C, 32'h4);
        write(8'h00, 32'h1);
        write(8'h04, 32'h23);
        seen(0, 20);
        check("plain detect", 32'h9, {28'h0, m});
        repeat (40) @(posedge aclk);
        $display("test link done");
    endtask

    task automatic t_rate;
        write(8'h10, 32'h2);
        write(8'h04, 32'h14);
        read(8'h04);
        check("rate mid", 32'h14, rd);
        write(8'h04, 32'h34);
        read(8'h04);
        check("rate bad", 32'h14, rd);
        write(8'h04, 32'h04);
        read(8'h04);
        check("rate high", 32'h04, rd);
        write(8'h00, 32'h9);
        read(8'h04);
        check("old version", 32'h14, rd);
        write(8'h04, 32'h04);
        read(8'h04);
        check("high refused", 32'h14, rd);
        write(8'h04, 32'h24);
        read(8'h04);
        check("rate low", 32'h24, rd);
        read(8'h0C);
        check("refuse stat", 32'h6, rd);
        write(8'h0C, 32'h7);
        read(8'h14);
        check("unmapped resp", 32'h2, {30'h0, rsp});
        check("unmapped data", 32'h0, rd);
        write(8'h08, 32'hFF);
        check("status write", 32'h2, {30'h0, rsp});
        $display("test rate and bus done");
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_trigger();
        t_link();
        t_rate();
        results();
    end
endmodule

// [tb/csl_status_led_props.sv]
/*
 checker for the status led controller bus and indicators.
 assumes binding to csl_status_led; sees only its ports.
*/
module csl_status_led_props (
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // indicators
    input wire [1:0]  power_trigger_indicator,
    input wire [1:0]  link_indicator
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_reset_amber: assert property ($rose(aresetn) |->
        power_trigger_indicator == 2'h3 && link_indicator == 2'h3)
        else $error("indicators not amber after reset");
    chk_power_red: assert property (power_trigger_indicator != 2'h2)
        else $error("power indicator red");
    chk_wr_busy: assert property (s_wr_taken |=>
        !s_axi_awready && !s_axi_wready)
        else $error("write readies stay high");
    chk_wr_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready)
        else $error("write response not released");
    chk_rd_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready)
        else $error("read response not released");
    chk_err_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
        |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read carries data");
endmodule

bind csl_status_led csl_status_led_props i_csl_status_led_props (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .power_trigger_indicator(power_trigger_indicator),
    .link_indicator(link_indicator));

// [tb/csl_trig_src.sv]
/*
 external trigger source: one-cycle pulses every gap+1 cycles.
 assumes the bench clock; idle low while disabled.
*/
module csl_trig_src (
    // clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // control
    input  wire       enable,
    input  wire [7:0] gap,
    // trigger
    output reg        trigger_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] count;
    always @(posedge aclk) begin
        if (!aresetn || !enable) begin
            count <= 8'h00;
            trigger_pulse <= 1'b0;
        end else begin
            count <= (count >= gap) ? 8'h00 : count + 8'h01;
            trigger_pulse <= (count == 8'h00);
        end
    end
endmodule
